// ### hdl/tmr_cmp_pkg.sv
// Purpose: Shared constants and types for the compare-output action block
// Assumes: Two timer instances, three compare channels each
// Notes:   APB register offsets are byte addresses
package tmr_cmp_pkg;

  localparam int NUM_TIMERS = 2;
  localparam int NUM_CHAN   = 3;

  // APB byte offsets
  localparam logic [4:0] OFS_T1_CTRL = 5'h00;
  localparam logic [4:0] OFS_T1_MODE = 5'h04;
  localparam logic [4:0] OFS_T3_CTRL = 5'h08;
  localparam logic [4:0] OFS_T3_MODE = 5'h0c;
  localparam logic [4:0] OFS_STATUS  = 5'h10;

  // Field positions (upper bit for channel A and WGM low, lower bit for mode and status) and field width
  localparam int FLD_A_HI     = 7;
  localparam int FLD_WIDTH    = 2;
  localparam int WGM_LO_HI    = 1;
  localparam int MODE_HI_POS  = 3;
  localparam int STAT_T3_POS  = 6;
  localparam int STAT_OVR_POS = 3;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // Output-action field values
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // Modes named for channel A toggling in PWM; 14 classifies as fast, so only 15 and 9 allow it
  localparam logic [3:0] MODE_FAST_TOGGLE   = 4'hf;
  localparam logic [3:0] MODE_DUAL_TOGGLE_A = 4'h9;
  localparam logic [3:0] MODE_DUAL_TOGGLE_B = 4'he;

  typedef enum logic [1:0] {CLS_NONPWM, CLS_FAST, CLS_DUAL} wave_class_t;

  typedef struct packed {
    logic [2:0] match;
    logic [2:0] eq_top;
    logic [2:0] dir;
    logic [2:0] port_data;
    logic       at_top;
    logic       count_down;
  } tmr_in_t;

  typedef struct packed {
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic [2:0] override;
  } tmr_pin_t;

  typedef struct packed {
    logic [NUM_TIMERS-1:0][7:0] ctrl;
    logic [NUM_TIMERS-1:0][1:0] mode_hi;
    logic [NUM_TIMERS-1:0][2:0] oc;
    tmr_pin_t [NUM_TIMERS-1:0]  pin;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
  } state_t;

  localparam state_t STATE_RESET = '0;

  // Mode 13 is reserved; treated as non-PWM
  function automatic wave_class_t classify(input logic [3:0] m);
    case (m)
      4'h0, 4'h4, 4'hc, 4'hd:       classify = CLS_NONPWM;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: classify = CLS_FAST;
      default:                      classify = CLS_DUAL;
    endcase
  endfunction

  function automatic logic [1:0] field(input logic [7:0] ctrl, input int c);
    field = ctrl[FLD_A_HI - FLD_WIDTH*c -: FLD_WIDTH];
  endfunction

endpackage

// ### hdl/timer16_compare_output_control.sv
// Purpose: Compare-output action control for two 16-bit timers, APB slave
// Assumes: Timer inputs synchronous to mclk; one match pulse per event
// Notes:   Pin mux inside drives pin_out from the compare output when override is high
// Function
// - Channel A action sits at control bits 7:6, B at 5:4, C at 3:2.
// - A nonzero action field routes the channel's compare output to its pin, except 01 where PWM forbids toggle.
// - A compare output reaches the pin only while the port direction is output.
// - Action value 0 disconnects the channel in every mode.
// - In non-PWM modes a match toggles on 01, clears on 10 and sets on 11.
// - In fast PWM, 10 clears on match and sets at top; 11 does the reverse.
// - In fast PWM, 01 toggles channel A only in mode 15, else disconnected.
// - In fast PWM with compare equal to top and upper bit set, only top acts.
// - In dual-slope PWM, 10 clears on up-count match and sets on down; 11 reverses.
// - In dual-slope PWM, 01 toggles channel A only in mode 9 (mode 14 classifies as fast).
// - The 4-bit mode joins the two low control bits with two upper mode bits.
// - Modes 0,4,12,13 are non-PWM, 5,6,7,14,15 fast, 1-3 and 8-11 dual-slope.
`timescale 1ns/1ps
module timer16_compare_output_control
(
  // Clock and reset
  input  wire logic                                          mclk,
  input  wire logic                                          resetn,
  // APB slave
  input  wire logic [31:0]                                   paddr,
  input  wire logic                                          psel,
  input  wire logic                                          penable,
  input  wire logic                                          pwrite,
  input  wire logic [31:0]                                   pwdata,
  output logic      [31:0]                                   prdata,
  output logic                                               pready,
  output logic                                               pslverr,
  // Timer events and port state
  input  wire tmr_cmp_pkg::tmr_in_t  [tmr_cmp_pkg::NUM_TIMERS-1:0] tmr_in,
  // Pin drive
  output tmr_cmp_pkg::tmr_pin_t      [tmr_cmp_pkg::NUM_TIMERS-1:0] tmr_pin
);

  logic [1:0]               rst_sync_r;
  logic                     rst_n_sync;
  tmr_cmp_pkg::state_t      q;
  tmr_cmp_pkg::state_t      n;
  logic [3:0]               mode;
  tmr_cmp_pkg::wave_class_t cls;
  logic [1:0]               act;
  logic                     toggle_ok;
  logic                     ovr;
  logic                     oc_v;
  logic                     addr_hit;
  logic                     wr_take;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'h1};
  end

  assign rst_n_sync = rst_sync_r[1];
  assign addr_hit   = (paddr[31:5] == 27'h0);
  assign wr_take    = psel & penable & q.pready & pwrite;

  always_comb
  begin
    n         = q;
    mode      = 4'h0;
    cls       = tmr_cmp_pkg::CLS_NONPWM;
    act       = tmr_cmp_pkg::ACT_OFF;
    toggle_ok = 1'h0;
    ovr       = 1'h0;
    oc_v      = 1'h0;

    // One wait state keeps pready registered
    n.pready  = psel & penable & !q.pready;
    n.pslverr = 1'h0;
    n.prdata  = 32'h0;
    if (n.pready)
    begin
      if (!addr_hit)
        n.pslverr = 1'h1;
      else
      begin
        case (paddr[4:0])
          tmr_cmp_pkg::OFS_T1_CTRL: n.prdata[7:0] = q.ctrl[0];
          tmr_cmp_pkg::OFS_T3_CTRL: n.prdata[7:0] = q.ctrl[1];
          tmr_cmp_pkg::OFS_T1_MODE:
            n.prdata[tmr_cmp_pkg::MODE_HI_POS +: 2] = q.mode_hi[0];
          tmr_cmp_pkg::OFS_T3_MODE:
            n.prdata[tmr_cmp_pkg::MODE_HI_POS +: 2] = q.mode_hi[1];
          tmr_cmp_pkg::OFS_STATUS:
          begin
            n.prdata[0 +: 3] = q.oc[0];
            n.prdata[tmr_cmp_pkg::STAT_OVR_POS +: 3] = q.pin[0].override;
            n.prdata[tmr_cmp_pkg::STAT_T3_POS +: 3] = q.oc[1];
            n.prdata[tmr_cmp_pkg::STAT_T3_POS + tmr_cmp_pkg::STAT_OVR_POS +: 3] =
              q.pin[1].override;
          end
          default: n.pslverr = 1'h1;
        endcase
      end
    end

    // Writes land on the completing edge only
    if (wr_take && addr_hit)
    begin
      case (paddr[4:0])
        tmr_cmp_pkg::OFS_T1_CTRL: n.ctrl[0] = pwdata[7:0];
        tmr_cmp_pkg::OFS_T3_CTRL: n.ctrl[1] = pwdata[7:0];
        tmr_cmp_pkg::OFS_T1_MODE:
          n.mode_hi[0] = pwdata[tmr_cmp_pkg::MODE_HI_POS +: 2];
        tmr_cmp_pkg::OFS_T3_MODE:
          n.mode_hi[1] = pwdata[tmr_cmp_pkg::MODE_HI_POS +: 2];
        default: ;
      endcase
    end

    for (int t = 0; t < tmr_cmp_pkg::NUM_TIMERS; t++)
    begin
      mode = {q.mode_hi[t], q.ctrl[t][tmr_cmp_pkg::WGM_LO_HI -: 2]};
      cls  = tmr_cmp_pkg::classify(mode);
      for (int c = 0; c < tmr_cmp_pkg::NUM_CHAN; c++)
      begin
        act = tmr_cmp_pkg::field(q.ctrl[t], c);
        // Toggle in PWM is a channel A privilege of a few modes
        toggle_ok = (cls == tmr_cmp_pkg::CLS_NONPWM) ||
                    ((c == 0) && (cls == tmr_cmp_pkg::CLS_FAST) &&
                     (mode == tmr_cmp_pkg::MODE_FAST_TOGGLE)) ||
                    ((c == 0) && (cls == tmr_cmp_pkg::CLS_DUAL) &&
                     ((mode == tmr_cmp_pkg::MODE_DUAL_TOGGLE_A) ||
                      (mode == tmr_cmp_pkg::MODE_DUAL_TOGGLE_B)));
        ovr  = (act != tmr_cmp_pkg::ACT_OFF) &&
               ((act != tmr_cmp_pkg::ACT_TOGGLE) || toggle_ok);
        oc_v = q.oc[t][c];
        if (ovr)
        begin
          case (cls)
            tmr_cmp_pkg::CLS_NONPWM:
            begin
              if (tmr_in[t].match[c])
              begin
                case (act)
                  tmr_cmp_pkg::ACT_TOGGLE: oc_v = !oc_v;
                  tmr_cmp_pkg::ACT_CLEAR:  oc_v = 1'h0;
                  default:                 oc_v = 1'h1;
                endcase
              end
            end
            tmr_cmp_pkg::CLS_FAST:
            begin
              if (act == tmr_cmp_pkg::ACT_TOGGLE)
              begin
                if (tmr_in[t].match[c])
                  oc_v = !oc_v;
              end
              else
              begin
                // Match at top is dropped; top action alone stands
                if (tmr_in[t].match[c] && !tmr_in[t].eq_top[c])
                  oc_v = (act == tmr_cmp_pkg::ACT_SET);
                if (tmr_in[t].at_top)
                  oc_v = (act == tmr_cmp_pkg::ACT_CLEAR);
              end
            end
            default:
            begin
              if (tmr_in[t].match[c])
              begin
                if (act == tmr_cmp_pkg::ACT_TOGGLE)
                  oc_v = !oc_v;
                else
                  oc_v = (act == tmr_cmp_pkg::ACT_SET) ^ tmr_in[t].count_down;
              end
            end
          endcase
        end
        n.oc[t][c]              = oc_v;
        n.pin[t].override[c]    = ovr;
        n.pin[t].pin_oe[c]      = tmr_in[t].dir[c];
        n.pin[t].pin_out[c]     = ovr ? oc_v : tmr_in[t].port_data[c];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      q <= tmr_cmp_pkg::STATE_RESET;
    else
      q <= n;
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign tmr_pin = q.pin;

  // Checks on timer 1 channel A (and B where noted), plus timer 3 channel A routing
  logic [3:0]               m0;
  tmr_cmp_pkg::wave_class_t c0;
  logic [1:0]               fa0;
  logic [1:0]               fb0;

  assign m0  = {q.mode_hi[0], q.ctrl[0][1:0]};
  assign c0  = tmr_cmp_pkg::classify(m0);
  assign fa0 = q.ctrl[0][7:6];
  assign fb0 = q.ctrl[0][5:4];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_sync);

  a_route_nonpwm: assert property (
    (c0 == tmr_cmp_pkg::CLS_NONPWM && fa0 != 2'h0) |=> q.pin[0].override[0])
    else $error("channel A not routed with nonzero field");

  a_zero_disc: assert property (
    (fa0 == 2'h0) |=> !q.pin[0].override[0])
    else $error("channel A routed with zero field");

  a_drive_dir: assert property (
    (q.pin[0].override[0] && q.pin[0].pin_oe[0]) |-> $past(tmr_in[0].dir[0]))
    else $error("compare output driven without output direction");

  a_nonpwm_set: assert property (
    (c0 == tmr_cmp_pkg::CLS_NONPWM && fa0 == 2'h3 && tmr_in[0].match[0])
    |=> (q.oc[0][0] && q.pin[0].pin_out[0]))
    else $error("non-PWM set on match failed");

  a_nonpwm_tog: assert property (
    (c0 == tmr_cmp_pkg::CLS_NONPWM && fa0 == 2'h1 && tmr_in[0].match[0])
    |=> (q.oc[0][0] != $past(q.oc[0][0])))
    else $error("non-PWM toggle on match failed");

  a_fast_top: assert property (
    (c0 == tmr_cmp_pkg::CLS_FAST && fa0 == 2'h2 && tmr_in[0].at_top)
    |=> q.oc[0][0])
    else $error("fast PWM set at top failed");

  a_fast_tog_gate: assert property (
    (c0 == tmr_cmp_pkg::CLS_FAST && m0 != 4'hf && fa0 == 2'h1)
    |=> !q.pin[0].override[0])
    else $error("fast PWM toggle routed outside mode 15");

  a_fast_eq_top: assert property (
    (c0 == tmr_cmp_pkg::CLS_FAST && fa0[1] && tmr_in[0].match[0] &&
     tmr_in[0].eq_top[0] && !tmr_in[0].at_top) |=> $stable(q.oc[0][0]))
    else $error("fast PWM match at top not ignored");

  a_dual_slope: assert property (
    (c0 == tmr_cmp_pkg::CLS_DUAL && fa0 == 2'h2 && tmr_in[0].match[0])
    |=> (q.oc[0][0] == $past(tmr_in[0].count_down)))
    else $error("dual-slope clear/set by direction failed");

  a_dual_tog_b: assert property (
    (c0 == tmr_cmp_pkg::CLS_DUAL && fb0 == 2'h1) |=> !q.pin[0].override[1])
    else $error("dual-slope toggle routed on channel B");

  a_mode_reserved: assert property (
    (m0 == 4'hd && fa0 == 2'h1 && tmr_in[0].match[0])
    |=> (q.oc[0][0] != $past(q.oc[0][0])))
    else $error("mode 13 not handled as non-PWM");

  a_nonpwm_clr: assert property (
    (c0 == tmr_cmp_pkg::CLS_NONPWM && fa0 == 2'h2 && tmr_in[0].match[0])
    |=> (!q.oc[0][0] && !q.pin[0].pin_out[0]))
    else $error("non-PWM clear on match failed");

  a_fast_clr_top: assert property (
    (c0 == tmr_cmp_pkg::CLS_FAST && fa0 == 2'h3 && tmr_in[0].at_top)
    |=> !q.oc[0][0])
    else $error("fast PWM clear at top failed");

  a_fast_match: assert property (
    (c0 == tmr_cmp_pkg::CLS_FAST && fa0 == 2'h2 && tmr_in[0].match[0] &&
     !tmr_in[0].eq_top[0] && !tmr_in[0].at_top) |=> !q.oc[0][0])
    else $error("fast PWM clear on match failed");

  a_fast_tog_a: assert property (
    (m0 == 4'hf && fa0 == 2'h1 && tmr_in[0].match[0])
    |=> (q.oc[0][0] != $past(q.oc[0][0])))
    else $error("fast PWM mode 15 toggle failed");

  a_dual_set_rev: assert property (
    (c0 == tmr_cmp_pkg::CLS_DUAL && fa0 == 2'h3 && tmr_in[0].match[0])
    |=> (q.oc[0][0] != $past(tmr_in[0].count_down)))
    else $error("dual-slope set/clear by direction failed");

  a_dual_tog_a: assert property (
    (m0 == 4'h9 && fa0 == 2'h1) |=> q.pin[0].override[0])
    else $error("dual-slope toggle not routed in mode 9");

  a_port_pass: assert property (
    (fa0 == 2'h0) |=> (q.pin[0].pin_out[0] == $past(tmr_in[0].port_data[0])))
    else $error("disconnected pin not under port control");

  a_t3_route: assert property (
    (q.ctrl[1][7:6] == 2'h3) |=> q.pin[1].override[0])
    else $error("timer 3 channel A not routed");

  a_ctrl_write: assert property (
    (wr_take && addr_hit && paddr[4:0] == tmr_cmp_pkg::OFS_T1_CTRL)
    |=> (q.ctrl[0] == $past(pwdata[7:0])))
    else $error("control write did not land");

  a_mode_write: assert property (
    (wr_take && addr_hit && paddr[4:0] == tmr_cmp_pkg::OFS_T1_MODE)
    |=> (q.mode_hi[0] == $past(pwdata[tmr_cmp_pkg::MODE_HI_POS +: 2])))
    else $error("upper mode bits write did not land");

endmodule

// ### testbench/pin_pad_model.sv
// Purpose: Pad model for the compare-output pins of one timer
// Assumes: Every pad has a pull-up
// Notes:   A released pad shows the pull-up level, never the last value
`timescale 1ns/1ps
module pin_pad_model
(
  // Pin drive from the block
  input  wire tmr_cmp_pkg::tmr_pin_t pin,
  // Pad level
  output logic [2:0]                 pad
);
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      pad[i] = pin.pin_oe[i] ? pin.pin_out[i] : 1'b1;
    end
  end
endmodule

// ### testbench/test_timer16_compare_output_control.sv
// Purpose: Self-checking bench for the compare-output action block
// Assumes: One wait state on every APB access
// Notes:   Status reads carry the compare outputs; only the direction and timer 3 checks rely on fixed pin timing
`timescale 1ns/1ps
module test_timer16_compare_output_control;
  logic                        mclk = 0;
  logic                        resetn = 0;
  logic                        psel = 0;
  logic                        penable = 0;
  logic                        pwrite = 0;
  logic [31:0]                 paddr = '0;
  logic [31:0]                 pwdata = '0;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  tmr_cmp_pkg::tmr_in_t  [1:0] tin = '0;
  tmr_cmp_pkg::tmr_pin_t [1:0] tpin;
  logic [2:0]                  pad;
  logic [64:0]                 notes[$];
  logic [64:0]                 nt;
  logic [31:0]                 w;
  int                          errors = 0;
  int                          comparisons = 0;
  int                          seed = 7523;

  initial forever #5 mclk = ~mclk;

  timer16_compare_output_control dut (.mclk(mclk), .resetn(resetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tmr_in(tin), .tmr_pin(tpin));
  pin_pad_model pads (.pin(tpin[0]), .pad(pad));

  task automatic check(logic [32:0] seen, logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Each access leaves a note: mask, then error flag and data
  task automatic apb(logic wr, logic [31:0] a, logic [31:0] d, logic [31:0] m, logic [32:0] e);
    int n;
    n = 0;
    notes.push_back({m, e});
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      errors++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge mclk)
  begin
    if (pready === 1'b1)
    begin
      nt = notes.pop_front();
      check({pslverr, prdata & nt[64:33]}, nt[32:0]);
    end
  end

  task automatic wr(logic [31:0] a, logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 33'h0);
  endtask

  task automatic rd(logic [31:0] a, logic [31:0] m, logic [32:0] e);
    apb(1'b0, a, 32'h0, m, e);
  endtask

  // Field of channel A plus the 4-bit mode split over two registers
  task automatic cfg(logic [1:0] f, logic [3:0] md);
    wr(32'h0, {24'h0, f, 4'h0, md[1:0]});
    wr(32'h4, {27'h0, md[3:2], 3'h0});
  endtask

  task automatic ev(logic m, logic top, logic dn);
    @(posedge mclk);
    tin[0].match <= {2'h0, m};
    tin[0].at_top <= top;
    tin[0].count_down <= dn;
    @(posedge mclk);
    tin[0].match <= 3'h0;
    tin[0].at_top <= 1'b0;
  endtask

  task automatic st(logic oc, logic ov, logic [31:0] m);
    rd(32'h10, m, {29'h0, ov, 2'h0, oc});
  endtask

  initial
  begin
    tin[0].dir = 3'h7;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int a = 0; a < 20; a += 4)
      rd(a, 32'hffffffff, 33'h0);
    rd(32'h14, 32'hffffffff, 33'h100000000);
    repeat (4)
    begin
      w = $random(seed);
      wr(32'h8, w);
      rd(32'h8, 32'hff, {25'h0, w[7:0]});
    end
    wr(32'h8, 32'h0);
    $display("register test done");
    cfg(2'h3, 4'h0);
    ev(1, 0, 0);
    st(1, 1, 32'h9);
    cfg(2'h2, 4'h0);
    ev(1, 0, 0);
    st(0, 1, 32'h9);
    cfg(2'h1, 4'h0);
    ev(1, 0, 0);
    st(1, 1, 32'h9);
    ev(1, 0, 0);
    st(0, 1, 32'h9);
    cfg(2'h0, 4'h0);
    st(0, 0, 32'h9);
    cfg(2'h3, 4'hc);
    ev(1, 0, 0);
    st(1, 1, 32'h9);
    cfg(2'h1, 4'hd);
    ev(1, 0, 0);
    st(0, 1, 32'h9);
    ev(1, 0, 0);
    st(1, 1, 32'h9);
    $display("non-PWM test done");
    cfg(2'h2, 4'h5);
    ev(1, 0, 0);
    st(0, 1, 32'h9);
    ev(0, 1, 0);
    st(1, 1, 32'h9);
    cfg(2'h3, 4'h5);
    ev(0, 1, 0);
    tin[0].eq_top <= 3'h1;
    ev(1, 0, 0);
    st(0, 1, 32'h9);
    tin[0].eq_top <= 3'h0;
    cfg(2'h1, 4'he);
    st(0, 0, 32'h8);
    cfg(2'h1, 4'hf);
    ev(1, 0, 0);
    st(1, 1, 32'h9);
    $display("fast PWM test done");
    cfg(2'h2, 4'h1);
    ev(1, 0, 0);
    st(0, 1, 32'h9);
    ev(1, 0, 1);
    st(1, 1, 32'h9);
    cfg(2'h3, 4'ha);
    ev(1, 0, 0);
    st(1, 1, 32'h9);
    ev(1, 0, 1);
    st(0, 1, 32'h9);
    cfg(2'h1, 4'hb);
    st(0, 0, 32'h8);
    cfg(2'h1, 4'h9);
    ev(1, 0, 0);
    st(1, 1, 32'h9);
    wr(32'h0, 32'h51);
    rd(32'h10, 32'h18, 33'h8);
    for (int i = 0; i < 16; i++)
    begin
      cfg(2'h1, 4'(i));
      st(1'b0, i inside {0, 4, 9, 12, 13, 15}, 32'h8);
    end
    $display("dual-slope test done");
    cfg(2'h2, 4'h0);
    ev(1, 0, 0);
    repeat (3) @(posedge mclk);
    check({30'h0, pad}, 33'h0);
    tin[0].dir <= 3'h0;
    repeat (3) @(posedge mclk);
    check({30'h0, pad}, 33'h7);
    $display("direction test done");
    wr(32'h8, 32'hc0);
    tin[1].port_data <= 3'h6;
    tin[1].dir <= 3'h7;
    tin[1].match <= 3'h1;
    @(posedge mclk);
    tin[1].match <= 3'h0;
    repeat (2) @(posedge mclk);
    check({24'h0, tpin[1]}, 33'h1f9);
    rd(32'h10, 32'hfc0, 33'h240);
    $display("timer 3 test done");
    complete_run();
  end
endmodule
